// >>> fmiq_assertions.sv
// Property checker for the indicator, queue status, command and frame-control outputs
`timescale 1ns/1ps
`default_nettype none
module fmiq_assertions (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Indicators
  input wire logic internalDestMatch,
  input wire logic externalDestMatch_n,
  input wire logic matchFlag,
  input wire logic copiedFlag,
  input wire logic setRecognized,
  input wire logic setCopied,
  // Queue status and commands
  input wire logic [2:0] queueStatusCode,
  input wire logic cmd1Strobe,
  input wire logic [7:0] cmd1Code,
  input wire logic cmd2Strobe,
  input wire logic [7:0] cmd2Code,
  // Frame control
  input wire logic firstWordValid,
  input wire logic [31:0] firstWord,
  input wire logic fcValid,
  input wire logic [7:0] fcByte,
  input wire logic [1:0] fcLane,
  input wire logic [1:0] daLane,
  input wire logic daInNextWord
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [31:0] lastWord;
  wire [7:0] laneByte = 8'(lastWord >> {~fcLane, 3'b000});
  always_ff @(posedge mclk) begin
    if (ce && firstWordValid) begin
      lastWord <= firstWord;
    end
  end
  a_no_code_four: assert property (queueStatusCode != 3'h4)
    else $error("reserved queue status code driven");
  a_no_match_idle: assert property (ce && !internalDestMatch && externalDestMatch_n
    |=> !matchFlag && !copiedFlag) else $error("flags set without a match");
  a_int_match_all: assert property (ce && internalDestMatch |=> matchFlag == copiedFlag)
    else $error("internal match gave a partial indication");
  a_flag_bit_tie: assert property (matchFlag == setRecognized && copiedFlag == setCopied)
    else $error("flag and delimiter bit disagree");
  a_match_needs_copy: assert property (matchFlag |-> copiedFlag)
    else $error("match flag without copied flag");
  a_fc_follows: assert property (ce && firstWordValid |=> fcValid)
    else $error("frame control not taken");
  a_fc_byte_lane: assert property (fcValid |-> fcByte == laneByte)
    else $error("frame control byte from wrong lane");
  a_da_after_fc: assert property (fcValid |-> daLane == 2'(fcLane + 2'h1) &&
    daInNextWord == (fcLane == 2'h3)) else $error("address lane does not follow");
  a_cmd1_reserved: assert property (cmd1Strobe |-> cmd1Code != 8'h18)
    else $error("reserved first command issued");
  a_cmd2_reserved: assert property (cmd2Strobe |-> !(cmd2Code inside {8'h01, 8'h02, 8'h08}))
    else $error("reserved second command issued");
  c_copy_only: cover property (copiedFlag && !matchFlag);
  c_last_lane: cover property (fcValid && fcLane == 2'h3);
  c_almost_full: cover property (queueStatusCode == 3'h7);
  c_cmd2: cover property (cmd2Strobe);
endmodule
bind fmiq_top fmiq_assertions chk (.mclk(mclk), .srst(srst), .ce(ce),
  .internalDestMatch(internalDestMatch), .externalDestMatch_n(externalDestMatch_n),
  .matchFlag(matchFlag), .copiedFlag(copiedFlag), .setRecognized(setRecognized),
  .setCopied(setCopied), .queueStatusCode(queueStatusCode), .cmd1Strobe(cmd1Strobe),
  .cmd1Code(cmd1Code), .cmd2Strobe(cmd2Strobe), .cmd2Code(cmd2Code),
  .firstWordValid(firstWordValid), .firstWord(firstWord), .fcValid(fcValid),
  .fcByte(fcByte), .fcLane(fcLane), .daLane(daLane), .daInNextWord(daInNextWord));
`default_nettype wire

// >>> fmiq_host_model.sv
// Host-side model that lays out the first transmit data word
`timescale 1ns/1ps
`default_nettype none
module fmiq_host_model (
  // Clock and request
  input wire logic mclk,
  input wire logic go,
  input wire logic [1:0] pos,
  input wire logic swap,
  input wire logic [7:0] fc,
  input wire logic [7:0] da,
  // First word towards the device
  output logic firstWordValid,
  output logic [31:0] firstWord
);
  // Spare lanes carry the inverse of frame control so a wrong lane pick shows
  wire [1:0] lane = swap ? ~pos : pos;
  logic [31:0] word;
  always_comb begin
    word = {4{~fc}};
    word[31 - 8 * lane -: 8] = fc;
    if (lane != 2'h3) begin
      word[23 - 8 * lane -: 8] = da;
    end
  end
  // Outside a transfer the word toggles instead of holding stale data
  always_ff @(posedge mclk) begin
    firstWordValid <= go;
    firstWord <= go ? word : ~firstWord;
  end
endmodule
`default_nettype wire

// >>> fmiq_indicator.sv
// Address-recognized / copied indicator decision for one received frame
`timescale 1ns/1ps
`default_nettype none
module fmiq_indicator
  import fmiq_pkg::*;
(
  // Configuration
  input wire logic [1:0] policy,
  input wire logic specialMode,
  input wire logic qualifyEnable,
  // Match inputs
  input wire logic internalDestMatch,
  input wire logic externalDestMatch_n,
  input wire logic externalMatchQualifier_n,
  // Decision
  output logic matchFlag,
  output logic copiedFlag,
  output logic setRecognized,
  output logic setCopied
);
  wire extActive = ~externalDestMatch_n;
  wire qualActive = ~externalMatchQualifier_n;
  logic fullSet;

  always_comb begin
    case (policy)
      POL_LEGACY: fullSet = ~specialMode;
      POL_ONLINE: fullSet = ~qualifyEnable | qualActive;
      POL_SPECIAL: fullSet = qualifyEnable & qualActive;
      default: fullSet = 1'b0;
    endcase
  end

  always_comb begin
    matchFlag = 1'b0;
    copiedFlag = 1'b0;
    setRecognized = 1'b0;
    setCopied = 1'b0;
    if (policy == POL_NONE) begin
      matchFlag = 1'b0;
    end else if (internalDestMatch) begin
      matchFlag = 1'b1;
      copiedFlag = 1'b1;
      setRecognized = 1'b1;
      setCopied = 1'b1;
    end else if (extActive) begin
      // External-only match: copied always, recognized only on full set
      matchFlag = fullSet;
      copiedFlag = 1'b1;
      setRecognized = fullSet;
      setCopied = 1'b1;
    end
    // No match leaves everything clear and the delimiter untouched
  end
endmodule
`default_nettype wire

// >>> fmiq_pkg.sv
// Constants for the MAC indicator, queue status and frame-control options block
package fmiq_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_MODE1 = 8'h00;
  localparam logic [7:0] OFF_MODE2 = 8'h04;
  localparam logic [7:0] OFF_MODE3 = 8'h08;
  localparam logic [7:0] OFF_CMD1 = 8'h0c;
  localparam logic [7:0] OFF_CMD2 = 8'h10;
  localparam logic [7:0] OFF_STATUS_ONE_UPPER = 8'h14;
  localparam logic [7:0] OFF_STATUS_ONE_LOWER = 8'h18;
  // Reset values
  localparam logic [15:0] RST_MODE1 = 16'h0000;
  localparam logic [15:0] RST_MODE2 = 16'h8000;
  localparam logic [15:0] RST_MODE3 = 16'h0000;
  // Field positions
  localparam int OPMODE_LO = 12;
  localparam int OPMODE_HI = 14;
  localparam int TAGMODE_BIT = 15;
  localparam int BYTEORDER_BIT = 11;
  localparam int POLICY_LO = 4;
  localparam int POLICY_HI = 5;
  localparam int QUALEN_BIT = 2;
  localparam int AFULLREP_BIT = 3;
  localparam int DUALRCV_BIT = 11;
  localparam int FCPOS_LO = 12;
  localparam int FCPOS_HI = 13;
  // Operating mode value that selects special online handling
  localparam logic [2:0] OPMODE_SPECIAL = 3'h2;
  // Indicator policy values
  localparam logic [1:0] POL_LEGACY = 2'h0;
  localparam logic [1:0] POL_ONLINE = 2'h1;
  localparam logic [1:0] POL_SPECIAL = 2'h2;
  localparam logic [1:0] POL_NONE = 2'h3;
  // Reserved command codes
  localparam logic [7:0] CMD1_RSV = 8'h18;
  localparam logic [7:0] CMD2_RSV_A = 8'h01;
  localparam logic [7:0] CMD2_RSV_B = 8'h02;
  localparam logic [7:0] CMD2_RSV_C = 8'h08;
  // Status one: bits 7..4 always read zero
  localparam logic [15:0] ST1_KEEP = 16'hff0f;
  // Host service request write codes
  localparam logic [2:0] HSR_WR_SYNC = 3'h5;
  localparam logic [2:0] HSR_WR_A0 = 3'h6;
  localparam logic [2:0] HSR_WR_A1 = 3'h7;
  // Queue status codes; 3'h4 is never produced
  localparam logic [2:0] QS_IDLE = 3'h0;
  localparam logic [2:0] QS_UNLD_SYNC = 3'h1;
  localparam logic [2:0] QS_UNLD_A0 = 3'h2;
  localparam logic [2:0] QS_A1 = 3'h3;
  localparam logic [2:0] QS_UNDERRUN = 3'h5;
  localparam logic [2:0] QS_FULL = 3'h6;
  localparam logic [2:0] QS_AFULL = 3'h7;
  // Unload queue selector
  typedef enum logic [1:0] {UNLD_NONE, UNLD_SYNC, UNLD_A0, UNLD_A1} fmiq_unld_t;
endpackage

// >>> fmiq_top.sv
// Indicator policy, queue status, command and frame-control options with APB registers
`timescale 1ns/1ps
`default_nettype none
module fmiq_top
  import fmiq_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int REG_W = 16
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state: initialize or memory-active
  input wire logic configAllowed,
  // Address match inputs
  input wire logic internalDestMatch,
  input wire logic externalDestMatch_n,
  input wire logic externalMatchQualifier_n,
  // Indicator results
  output logic matchFlag,
  output logic copiedFlag,
  output logic setRecognized,
  output logic setCopied,
  // Host queue interface
  input wire logic hostWrite,
  input wire logic [2:0] hostServiceRequest,
  input wire logic queueFull,
  input wire logic aboveThreshold,
  input wire logic txUnderrun,
  input wire logic [1:0] unloadQueue,
  output logic [2:0] queueStatusCode,
  // Transmit first data word
  input wire logic firstWordValid,
  input wire logic [DATA_W-1:0] firstWord,
  output logic fcValid,
  output logic [7:0] fcByte,
  output logic [1:0] fcLane,
  output logic [1:0] daLane,
  output logic daInNextWord,
  // Status inputs from the MAC core
  input wire logic [REG_W-1:0] statusUpperIn,
  input wire logic [REG_W-1:0] statusLowerIn,
  // Command strobes and mode outputs
  output logic cmd1Strobe,
  output logic [7:0] cmd1Code,
  output logic cmd2Strobe,
  output logic [7:0] cmd2Code,
  output logic tagMode,
  output logic tagModeBothQueues
);
  logic [REG_W-1:0] modeOne;
  logic [REG_W-1:0] modeTwo;
  logic [REG_W-1:0] modeThree;
  logic afullSeen;

  // Bus decode
  wire setupPhase = psel & ~penable;
  wire writeTaken = psel & penable & pready & pwrite;
  wire hitMode1 = paddr == OFF_MODE1;
  wire hitMode2 = paddr == OFF_MODE2;
  wire hitMode3 = paddr == OFF_MODE3;
  wire hitCmd1 = paddr == OFF_CMD1;
  wire hitCmd2 = paddr == OFF_CMD2;
  wire hitSt1u = paddr == OFF_STATUS_ONE_UPPER;
  wire hitSt1l = paddr == OFF_STATUS_ONE_LOWER;
  // Third async queue registers are simply absent: they decode as unmapped
  wire mapped = hitMode1 | hitMode2 | hitMode3 | hitCmd1 | hitCmd2 | hitSt1u | hitSt1l;
  wire [15:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wdata16 = pwdata[15:0];
  // Write enables per register; command writes need the low byte lane
  wire wrMode1 = writeTaken & hitMode1;
  wire wrMode2 = writeTaken & hitMode2;
  wire wrCmd1 = writeTaken & hitCmd1 & pstrb[0];
  wire wrCmd2 = writeTaken & hitCmd2 & pstrb[0];

  // Register fields
  wire [1:0] policy = modeThree[POLICY_HI:POLICY_LO];
  wire qualifyEnable = modeThree[QUALEN_BIT];
  wire afullRepeat = modeThree[AFULLREP_BIT];
  wire [1:0] fcPosition = modeThree[FCPOS_HI:FCPOS_LO];
  wire byteOrder = modeTwo[BYTEORDER_BIT];
  wire specialMode = modeOne[OPMODE_HI:OPMODE_LO] == OPMODE_SPECIAL;

  // Read mux
  wire [15:0] st1uRead = statusUpperIn & ST1_KEEP;
  wire [15:0] st1lRead = statusLowerIn & ST1_KEEP;
  wire [15:0] readMux = hitMode1 ? modeOne :
                        hitMode2 ? modeTwo :
                        hitMode3 ? modeThree :
                        hitSt1u ? st1uRead :
                        hitSt1l ? st1lRead : 16'h0000;

  // Register next values
  wire [15:0] next_modeOne = (modeOne & ~laneMask) | (wdata16 & laneMask);
  wire [15:0] next_modeTwo = (modeTwo & ~laneMask) | (wdata16 & laneMask);
  wire [15:0] next_modeThree = (modeThree & ~laneMask) | (wdata16 & laneMask);
  // Outside the permitted device states a mode three write is dropped silently
  wire wrMode3 = writeTaken & hitMode3 & configAllowed;

  // Command decode
  wire [7:0] wcode = pwdata[7:0];
  wire cmd1Reserved = wcode == CMD1_RSV;
  wire cmd2Reserved = (wcode == CMD2_RSV_A) | (wcode == CMD2_RSV_B) |
                      (wcode == CMD2_RSV_C);
  wire cmd1Go = wrCmd1 & ~cmd1Reserved;
  wire cmd2Go = wrCmd2 & ~cmd2Reserved;

  // Indicator decision
  logic indMatch;
  logic indCopied;
  logic indSetA;
  logic indSetC;

  fmiq_indicator u_indicator (
    .policy(policy),
    .specialMode(specialMode),
    .qualifyEnable(qualifyEnable),
    .internalDestMatch(internalDestMatch),
    .externalDestMatch_n(externalDestMatch_n),
    .externalMatchQualifier_n(externalMatchQualifier_n),
    .matchFlag(indMatch),
    .copiedFlag(indCopied),
    .setRecognized(indSetA),
    .setCopied(indSetC)
  );

  // Queue status selection
  wire isWriteReq = (hostServiceRequest == HSR_WR_SYNC) |
                    (hostServiceRequest == HSR_WR_A0) |
                    (hostServiceRequest == HSR_WR_A1);
  wire hostWriteCycle = hostWrite & isWriteReq;
  // Without repeat the almost-full code shows once until the level drops below threshold or the queue goes full
  wire showAfull = aboveThreshold & ~queueFull & (afullRepeat | ~afullSeen);
  wire [2:0] writeCode = (hostServiceRequest == HSR_WR_A1) ? QS_A1 : QS_IDLE;
  logic [2:0] unloadCode;
  always_comb begin
    case (unloadQueue)
      UNLD_SYNC: unloadCode = QS_UNLD_SYNC;
      UNLD_A0: unloadCode = QS_UNLD_A0;
      UNLD_A1: unloadCode = QS_A1;
      default: unloadCode = QS_IDLE;
    endcase
  end
  // Every branch yields a listed code, so 3'h4 cannot appear
  wire [2:0] next_queueStatusCode = txUnderrun ? QS_UNDERRUN :
                                    ~hostWriteCycle ? unloadCode :
                                    queueFull ? QS_FULL :
                                    showAfull ? QS_AFULL : writeCode;
  wire next_afullSeen = aboveThreshold & ~queueFull &
                        (afullSeen | (hostWriteCycle & ~txUnderrun));

  // Frame-control lane: lane 0 is the most significant byte
  wire [1:0] next_fcLane = byteOrder ? ~fcPosition : fcPosition;
  wire [2:0] daSum = {1'b0, next_fcLane} + 3'h1;
  logic [7:0] laneBytes [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign laneBytes[gi] = firstWord[DATA_W-1-8*gi -: 8];
    end
  endgenerate

  // Bus response: prdata and pslverr latched at the setup edge and held until the next setup; pready high for the one access cycle
  wire next_pready = setupPhase;
  wire [31:0] readWord = {16'h0000, readMux};
  wire [31:0] next_prdata = pwrite ? 32'h0000_0000 : readWord;
  // Unmapped includes the removed third-queue registers
  wire next_pslverr = ~mapped;

  // A reserved code is swallowed whole: no strobe, and the last code stays
  wire next_cmd1Strobe = cmd1Go;
  wire next_cmd2Strobe = cmd2Go;

  // First-word results for the selected lane
  wire [7:0] next_fcByte = laneBytes[next_fcLane];
  wire [1:0] next_daLane = daSum[1:0];
  // Lane 3 holds frame control last, so the address starts in the next word
  wire next_daInNextWord = daSum[2];

  // Buffer mode outputs trail the mode registers by one edge
  wire next_tagMode = modeTwo[TAGMODE_BIT];
  wire next_tagModeBothQueues = modeThree[DUALRCV_BIT];

  // All state below holds while ce is low
  // Bus slave: one setup, one access cycle, no wait states
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= next_pready;
      if (setupPhase) begin
        prdata <= next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  // Mode registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      modeOne <= RST_MODE1;
      modeTwo <= RST_MODE2;
      modeThree <= RST_MODE3;
    end else if (ce) begin
      if (wrMode1) begin
        modeOne <= next_modeOne;
      end
      if (wrMode2) begin
        modeTwo <= next_modeTwo;
      end
      if (wrMode3) begin
        modeThree <= next_modeThree;
      end
    end
  end

  // Commands: reserved codes produce no strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd1Strobe <= 1'b0;
      cmd2Strobe <= 1'b0;
      cmd1Code <= 8'h00;
      cmd2Code <= 8'h00;
    end else if (ce) begin
      cmd1Strobe <= next_cmd1Strobe;
      cmd2Strobe <= next_cmd2Strobe;
      if (cmd1Go) begin
        cmd1Code <= wcode;
      end
      if (cmd2Go) begin
        cmd2Code <= wcode;
      end
    end
  end

  // Indicator outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      matchFlag <= 1'b0;
      copiedFlag <= 1'b0;
      setRecognized <= 1'b0;
      setCopied <= 1'b0;
    end else if (ce) begin
      matchFlag <= indMatch;
      copiedFlag <= indCopied;
      setRecognized <= indSetA;
      setCopied <= indSetC;
    end
  end

  // Queue status
  always_ff @(posedge mclk) begin
    if (srst) begin
      queueStatusCode <= QS_IDLE;
      afullSeen <= 1'b0;
    end else if (ce) begin
      queueStatusCode <= next_queueStatusCode;
      afullSeen <= next_afullSeen;
    end
  end

  // Frame-control capture from the first transmit long word
  always_ff @(posedge mclk) begin
    if (srst) begin
      fcValid <= 1'b0;
      fcByte <= 8'h00;
      fcLane <= 2'h0;
      daLane <= 2'h1;
      daInNextWord <= 1'b0;
    end else if (ce) begin
      fcValid <= firstWordValid;
      if (firstWordValid) begin
        fcByte <= next_fcByte;
        fcLane <= next_fcLane;
        daLane <= next_daLane;
        daInNextWord <= next_daInNextWord;
      end
    end
  end

  // Mode outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      tagMode <= 1'b1;
      tagModeBothQueues <= 1'b0;
    end else if (ce) begin
      tagMode <= next_tagMode;
      tagModeBothQueues <= next_tagModeBothQueues;
    end
  end
endmodule
`default_nettype wire

// >>> tb_fmiq_top.sv
// Self-checking bench for the indicator, queue status and frame-control options block
`timescale 1ns/1ps
`default_nettype none
module tb_fmiq_top;
  import fmiq_pkg::*;
  logic mclk, srst, ce, psel, penable, pwrite, pready, pslverr, configAllowed, rerr, go, swap;
  logic [7:0] paddr, fcByte, cmd1Code, cmd2Code, fc, da;
  logic [31:0] pwdata, prdata, rdat, firstWord;
  logic [3:0] pstrb;
  logic internalDestMatch, externalDestMatch_n, externalMatchQualifier_n, hostWrite;
  logic matchFlag, copiedFlag, setRecognized, setCopied, queueFull, aboveThreshold, txUnderrun;
  logic [2:0] hostServiceRequest, queueStatusCode;
  logic [1:0] unloadQueue, fcLane, daLane, pos;
  logic firstWordValid, fcValid, daInNextWord, cmd1Strobe, cmd2Strobe, tagMode, tagModeBoth;
  logic [15:0] statusUpperIn, statusLowerIn;
  int miscompares, check_count, cyc, n1, n2, armed, lane;
  fmiq_top uut (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .configAllowed(configAllowed),
    .internalDestMatch(internalDestMatch), .externalDestMatch_n(externalDestMatch_n),
    .externalMatchQualifier_n(externalMatchQualifier_n), .matchFlag(matchFlag),
    .copiedFlag(copiedFlag), .setRecognized(setRecognized), .setCopied(setCopied),
    .hostWrite(hostWrite), .hostServiceRequest(hostServiceRequest), .queueFull(queueFull),
    .aboveThreshold(aboveThreshold), .txUnderrun(txUnderrun), .unloadQueue(unloadQueue),
    .queueStatusCode(queueStatusCode), .firstWordValid(firstWordValid),
    .firstWord(firstWord), .fcValid(fcValid), .fcByte(fcByte), .fcLane(fcLane),
    .daLane(daLane), .daInNextWord(daInNextWord), .statusUpperIn(statusUpperIn),
    .statusLowerIn(statusLowerIn), .cmd1Strobe(cmd1Strobe), .cmd1Code(cmd1Code),
    .cmd2Strobe(cmd2Strobe), .cmd2Code(cmd2Code), .tagMode(tagMode),
    .tagModeBothQueues(tagModeBoth));
  fmiq_host_model host (.mclk(mclk), .go(go), .pos(pos), .swap(swap), .fc(fc), .da(da),
    .firstWordValid(firstWordValid), .firstWord(firstWord));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    n1 += (cmd1Strobe === 1'b1);
    n2 += (cmd2Strobe === 1'b1);
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready and takes the answer at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [3:0] ind(int p, int s, int q, bit im, bit xm, bit xq);
    bit full;
    full = (p == 0) ? !s : (q ? xq : p == 1);
    if (p == 3 || (!im && !xm)) return 4'h0;
    if (im) return 4'hf;
    return full ? 4'hf : 4'h5;
  endfunction
  task automatic qstep(input bit hw, input int req, input bit fu, ab, un, input int ul, rep);
    int e;
    bit uw;
    uw = hw && req >= 5;
    @(posedge mclk);
    hostWrite <= hw;
    hostServiceRequest <= 3'(req);
    queueFull <= fu;
    aboveThreshold <= ab;
    txUnderrun <= un;
    unloadQueue <= 2'(ul);
    if (un) e = 5;
    else if (!uw) e = ul;
    else if (fu) e = 6;
    else if (ab && (rep || armed)) e = 7;
    else if (req == 7) e = 3;
    else e = 0;
    if (!ab || fu) armed = 1;
    else if (uw && !un) armed = 0;
    @(posedge mclk);
    #1 chk("queue status", queueStatusCode, 32'(e));
  endtask
  initial begin
    void'($urandom(24));
    {srst, ce, configAllowed, pstrb, armed} = {3'b111, 4'hf, 32'd1};
    {psel, penable, pwrite, paddr, pwdata, go, swap, pos, fc, da} = '0;
    {internalDestMatch, externalDestMatch_n, externalMatchQualifier_n} = 3'b011;
    {hostWrite, hostServiceRequest, queueFull, aboveThreshold, txUnderrun, unloadQueue} = '0;
    statusUpperIn = 16'($urandom);
    statusLowerIn = 16'($urandom);
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    apb(0, OFF_MODE2, 0);
    chk("mode two", rdat, 32'h8000);
    chk("tag mode", tagMode, 1);
    apb(0, OFF_MODE3, 0);
    chk("mode three", rdat, 0);
    apb(0, 8'h1c, 0);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    apb(0, OFF_STATUS_ONE_UPPER, 0);
    chk("status upper", rdat, statusUpperIn & 16'hff0f);
    apb(0, OFF_STATUS_ONE_LOWER, 0);
    chk("status lower", rdat, statusLowerIn & 16'hff0f);
    for (int p = 0; p < 4; p++) for (int s = 0; s < 2; s++) for (int q = 0; q < 2; q++) begin
      apb(1, OFF_MODE1, 32'(s) << 13);
      apb(1, OFF_MODE3, (32'(p) << 4) | (32'(q) << 2));
      for (int m = 0; m < 8; m++) begin
        @(posedge mclk);
        {externalMatchQualifier_n, externalDestMatch_n, internalDestMatch} <= 3'(m);
        @(posedge mclk);
        #1 chk("indicators", {matchFlag, copiedFlag, setRecognized, setCopied},
          ind(p, s, q, m[0], !m[1], !m[2]));
      end
    end
    configAllowed <= 1'b0;
    apb(1, OFF_MODE3, 32'h8);
    apb(0, OFF_MODE3, 0);
    chk("gated mode three", rdat, 32'h34);
    configAllowed <= 1'b1;
    apb(1, OFF_CMD1, 32'h2c);
    apb(1, OFF_CMD1, 32'h18);
    for (int c = 0; c < 4; c++) apb(1, OFF_CMD2, 32'h1 << c);
    repeat (2) @(posedge mclk);
    chk("command one strobes", n1, 1);
    chk("command one code", cmd1Code, 8'h2c);
    chk("command two strobes", n2, 1);
    chk("command two code", cmd2Code, 8'h04);
    qstep(0, 0, 0, 0, 1, 2, 0);
    for (int u = 0; u < 4; u++) qstep(0, 6, 0, 0, 0, u, 0);
    qstep(1, 7, 0, 0, 0, 0, 0);
    qstep(1, 5, 1, 1, 0, 0, 0);
    repeat (2) qstep(1, 6, 0, 1, 0, 0, 0);
    apb(1, OFF_MODE3, 32'h8);
    repeat (3) qstep(1, 7, 0, 1, 0, 1, 1);
    repeat (20) qstep(1'($urandom), $urandom % 8, 1'($urandom), 1'($urandom), 1'($urandom),
      $urandom % 4, 1);
    for (int b = 0; b < 2; b++) begin
      apb(1, OFF_MODE2, b ? 32'h0800 : 32'h8000);
      @(posedge mclk);
      #1 chk("tag select", tagMode, !b);
      for (int p = 0; p < 4; p++) begin
        apb(1, OFF_MODE3, (32'(p) << 12) | (32'(b) << 11));
        lane = b ? 3 - p : p;
        @(posedge mclk);
        {go, pos, swap, fc, da} <= {1'b1, 2'(p), 1'(b), 16'($urandom)};
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1 chk("fc byte", {fcValid, fcByte}, {1'b1, fc});
        chk("fc lane", fcLane, lane);
        chk("da lane", {daInNextWord, daLane}, {lane == 3, 2'(lane + 1)});
        chk("both queues", tagModeBoth, b);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
